// file: core/tck_consts.svh
// Purpose: constants of the link clock and reset plan
// Assumes: clock rates in kHz, line rate threshold in Mb/s, single 25 MHz block clock
// Notes:   included by bare name
`ifndef TCK_CONSTS_SVH
`define TCK_CONSTS_SVH
`define TCK_CLK_KHZ         25000
`define TCK_AUD_RATIO       128
`define TCK_HOST_KHZ        100000
`define TCK_HI_RATE_MBPS    3400
`define TCK_CABLE_DIV_LO    10
`define TCK_CABLE_DIV_HI    40
`define TCK_DATA_MUL_HI     4
`define TCK_LINK_DIV        4
`define TCK_BPC_8           2'h0
`define TCK_BPC_10          2'h1
`define TCK_BPC_12          2'h2
`define TCK_BPC_16          2'h3
`define TCK_RST_HOLD        16
`define TCK_NUM_DOMAINS     5
`endif

// file: core/tck_pkg.sv
// Purpose: types of the link clock and reset plan
// Assumes: nothing
// Notes:   constants live in tck_consts.svh
package tck_pkg;
   typedef enum logic [1:0] {
      TCK_ST_RESET = 2'b00,
      TCK_ST_HOLD  = 2'b01,
      TCK_ST_RUN   = 2'b10
   } tck_state_t;
   typedef struct packed {
      logic [15:0] rate_mbps;
      logic [1:0]  bpc_sel;
      logic        quad_px;
      logic        native_sel;
   } tck_cfg_t;
   typedef struct packed {
      logic [31:0] cable_khz;
      logic [31:0] data_khz;
      logic [31:0] link_khz;
      logic [31:0] pixel_khz;
      logic [31:0] video_khz;
   } tck_rates_t;
endpackage

// file: core/tck_sync.sv
// Purpose: two-stage level synchroniser
// Assumes: input from another clock or a pin
// Notes:   first stage read only by the second
module tck_sync
(
   input  wire logic clock_i,
   input  wire logic ce_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   input  wire logic rst_val_i,
   output logic      sync_o
);
   logic meta_q;
   logic meta_d;
   logic sync_d;

   always_comb
   begin
      meta_d = ce_i ? async_i : meta_q;
      sync_d = ce_i ? meta_q : sync_o;
   end

   // reset level tied per instance, so each use picks its safe side
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         meta_q <= rst_val_i;
         sync_o <= rst_val_i;
      end
      else
      begin
         meta_q <= meta_d;
         sync_o <= sync_d;
      end
   end
endmodule

// file: core/tck_plan.sv
// Purpose: clock relation calculator and per-domain reset manager
// Assumes: 25 MHz clock_i; domain resets and clock lock given as levels
// Notes:   derives cable, data, link, pixel, video rates from config
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
`include "tck_consts.svh"

module tck_plan
#(
   parameter int HOLD_CYCLES = `TCK_RST_HOLD
)
(
   input  wire logic              clock_i,
   input  wire logic              ce_i,
   input  wire logic              rst_i,
   input  wire tck_pkg::tck_cfg_t cfg_i,
   input  wire logic              host_rst_n_i,
   input  wire logic              vid_rst_n_i,
   input  wire logic              aud_rst_n_i,
   input  wire logic              clk_locked_i,
   output tck_pkg::tck_rates_t    rates_o,
   output logic                   host_rst_n_o,
   output logic                   vid_rst_n_o,
   output logic                   aud_rst_n_o,
   output logic                   video_rst_o,
   output logic                   ready_o
);
   // the hold counter is only 16 bits wide
   if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535)
   begin
      $error("HOLD_CYCLES out of range");
   end

   //------------------------------------------------------------------
   // synchronisers for external levels
   //------------------------------------------------------------------
   // one per foreign domain; no phase relation is assumed
   logic host_s;
   logic vid_s;
   logic aud_s;
   logic lock_s;

   tck_sync u_host (.clock_i(clock_i), .ce_i(ce_i), .rst_i(rst_i),
      .async_i(host_rst_n_i), .rst_val_i(1'b0), .sync_o(host_s));
   tck_sync u_vid  (.clock_i(clock_i), .ce_i(ce_i), .rst_i(rst_i),
      .async_i(vid_rst_n_i), .rst_val_i(1'b0), .sync_o(vid_s));
   tck_sync u_aud  (.clock_i(clock_i), .ce_i(ce_i), .rst_i(rst_i),
      .async_i(aud_rst_n_i), .rst_val_i(1'b0), .sync_o(aud_s));
   tck_sync u_lock (.clock_i(clock_i), .ce_i(ce_i), .rst_i(rst_i),
      .async_i(clk_locked_i), .rst_val_i(1'b0), .sync_o(lock_s));

   //------------------------------------------------------------------
   // rate relations
   //------------------------------------------------------------------
   tck_pkg::tck_rates_t rates_d;
   logic [31:0]         rate_khz;
   logic                hi_rate;

   always_comb
   begin
      rate_khz = {16'h0000, cfg_i.rate_mbps} * 32'h0000_03E8;
      hi_rate  = cfg_i.rate_mbps > 16'(`TCK_HI_RATE_MBPS);
      rates_d.cable_khz = hi_rate ? rate_khz / `TCK_CABLE_DIV_HI
                                  : rate_khz / `TCK_CABLE_DIV_LO;
      rates_d.data_khz  = hi_rate ? rates_d.cable_khz * `TCK_DATA_MUL_HI
                                  : rates_d.cable_khz;
      rates_d.link_khz  = rates_d.data_khz / `TCK_LINK_DIV;
      case (cfg_i.bpc_sel)
         `TCK_BPC_8:  rates_d.pixel_khz = rates_d.data_khz;
         `TCK_BPC_10: rates_d.pixel_khz = (rates_d.data_khz * 4) / 5;
         `TCK_BPC_12: rates_d.pixel_khz = (rates_d.data_khz * 2) / 3;
         default:     rates_d.pixel_khz = rates_d.data_khz / 2;
      endcase
      rates_d.video_khz = cfg_i.quad_px ? rates_d.pixel_khz / 4
                                        : rates_d.pixel_khz / 2;
      // frozen with the rest of the state
      if (!ce_i)
         rates_d = rates_o;
   end

   //------------------------------------------------------------------
   // reset sequencer
   //------------------------------------------------------------------
   tck_pkg::tck_state_t state_q;
   tck_pkg::tck_state_t state_d;
   logic [15:0]         cnt_q;
   logic [15:0]         cnt_d;
   logic                all_ok;

   // releases only after lock stays for the hold count
   always_comb
   begin
      all_ok  = lock_s;
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         tck_pkg::TCK_ST_RESET:
         begin
            cnt_d = 16'h0000;
            if (all_ok)
               state_d = tck_pkg::TCK_ST_HOLD;
         end
         tck_pkg::TCK_ST_HOLD:
         begin
            cnt_d = cnt_q + 16'h0001;
            if (!all_ok)
               state_d = tck_pkg::TCK_ST_RESET;
            else if (cnt_q == 16'(HOLD_CYCLES - 1))
               state_d = tck_pkg::TCK_ST_RUN;
         end
         tck_pkg::TCK_ST_RUN:
         begin
            if (!all_ok)
               state_d = tck_pkg::TCK_ST_RESET;
         end
         default:
            state_d = tck_pkg::TCK_ST_RESET;
      endcase
      if (!ce_i)
      begin
         state_d = state_q;
         cnt_d   = cnt_q;
      end
   end

   logic run_d;
   logic host_d;
   logic vid_d;
   logic aud_d;
   logic vrst_d;

   always_comb
   begin
      run_d  = state_d == tck_pkg::TCK_ST_RUN;
      host_d = run_d && host_s;
      aud_d  = run_d && aud_s;
      // native mode ignores the video reset input
      vid_d  = run_d && (cfg_i.native_sel || vid_s);
      vrst_d = !(run_d && cfg_i.native_sel);
      if (!ce_i)
      begin
         host_d = host_rst_n_o;
         aud_d  = aud_rst_n_o;
         vid_d  = vid_rst_n_o;
         vrst_d = video_rst_o;
         run_d  = ready_o;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_q      <= tck_pkg::TCK_ST_RESET;
         cnt_q        <= 16'h0000;
         host_rst_n_o <= 1'b0;
         vid_rst_n_o  <= 1'b0;
         aud_rst_n_o  <= 1'b0;
         video_rst_o  <= 1'b1;
         ready_o      <= 1'b0;
         rates_o      <= '0;
      end
      else
      begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         host_rst_n_o <= host_d;
         vid_rst_n_o  <= vid_d;
         aud_rst_n_o  <= aud_d;
         video_rst_o  <= vrst_d;
         ready_o      <= run_d;
         rates_o      <= rates_d;
      end
   end

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   default clocking cb_chk @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   // lock seen while idle, then the hold count starts from zero
   sequence lock_seen_s;
      ce_i && lock_s && state_q == tck_pkg::TCK_ST_RESET;
   endsequence
   sequence hold_start_s;
      state_q == tck_pkg::TCK_ST_HOLD && cnt_q == 16'h0000;
   endsequence

   AST_LINK_QUARTER: assert property (
      ce_i |=> rates_o.link_khz == rates_o.data_khz / 4)
      else $error("link rate not data/4");
   AST_DATA_REL: assert property (
      (ce_i && $stable(cfg_i)) |=> (rates_o.data_khz ==
      rates_o.cable_khz) || (rates_o.data_khz == rates_o.cable_khz * 4))
      else $error("data rate not 1x or 4x cable");
   AST_PIX8: assert property (
      (ce_i && cfg_i.bpc_sel == `TCK_BPC_8) |=>
      rates_o.pixel_khz == rates_o.data_khz)
      else $error("8 bpc pixel rate wrong");
   AST_VIDEO_DIV: assert property (
      (ce_i && cfg_i.quad_px) |=>
      rates_o.video_khz == rates_o.pixel_khz / 4)
      else $error("quad video rate wrong");
   AST_HOST_RST: assert property (
      !ready_o |-> !host_rst_n_o && !aud_rst_n_o)
      else $error("reset released before run");
   AST_VID_RST: assert property (
      !ready_o |-> !vid_rst_n_o)
      else $error("video reset released before run");
   // the output follows the mode seen at the edge that launched it
   AST_NATIVE_RST: assert property (
      (ready_o && $past(ce_i) && !$past(cfg_i.native_sel)) |-> video_rst_o)
      else $error("video reset released outside native mode");
   AST_HOLD: assert property (
      $rose(ready_o) |-> $past(lock_s, 2))
      else $error("release without stable lock");
   AST_HOLD_ENTRY: assert property (
      lock_seen_s |=> hold_start_s)
      else $error("hold count not started on lock");
   AST_LOCK_LOSS: assert property (
      (ce_i && !lock_s) |=> !ready_o)
      else $error("still running after lock loss");
   // kHz per Mb/s: 100 at one tenth, 25 at one fortieth
   AST_CABLE_LO: assert property (
      (ce_i && cfg_i.rate_mbps <= 16'(`TCK_HI_RATE_MBPS)) |=>
      rates_o.cable_khz == rates_o.data_khz &&
      rates_o.cable_khz ==
      {16'h0000, $past(cfg_i.rate_mbps)} * 32'h0000_0064)
      else $error("low rate cable clock wrong");
   AST_CABLE_HI: assert property (
      (ce_i && cfg_i.rate_mbps > 16'(`TCK_HI_RATE_MBPS)) |=>
      rates_o.cable_khz ==
      {16'h0000, $past(cfg_i.rate_mbps)} * 32'h0000_0019)
      else $error("high rate cable clock wrong");
endmodule

// file: tb/tck_src_model.sv
// Purpose: clock generator lock and reset sources facing the plan block
// Assumes: the bench moves lock_req_i and hold_n_i at the falling edge
// Notes:   resets are gated by lock, as a system integrator would wire it
`include "tck_consts.svh"

module tck_src_model
#(
   parameter int AUD_FS_HZ = 48000
)
(
   input  wire logic       lock_req_i,
   input  wire logic [2:0] hold_n_i,
   output logic            locked_o,
   output logic [2:0]      rst_n_o,
   output int              host_khz_o,
   output int              aud_hz_o
);
   timeunit 1ns;
   timeprecision 1ps;
   //------------------------------------------------------------------
   // lock and resets
   //------------------------------------------------------------------
   assign locked_o = lock_req_i;
   // held in reset until lock, so release follows clock stability
   assign rst_n_o  = {3{locked_o}} & hold_n_i;
   // supplied clock rates; the block regenerates no audio clock
   assign host_khz_o = `TCK_HOST_KHZ;
   assign aud_hz_o   = AUD_FS_HZ * `TCK_AUD_RATIO;
endmodule

// file: tb/tck_plan_bench.sv
// Purpose: self-checking bench of the clock relation and reset block
// Assumes: 25 MHz clock, inputs moved at the falling edge
// Notes:   short hold count keeps the run brief
`include "tck_consts.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
   mismatches++; $display("unexpected at %0t: %0h vs %0h", $time, \
   got, exp); end end
module tck_plan_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 2;
   localparam int AUD_FS = 48000;
   logic                clock_i = 1'b0;
   logic                rst_i   = 1'b1;
   logic                ce      = 1'b1;
   int                  host_khz;
   int                  aud_hz;
   logic                lock_req = 1'b0;
   logic [2:0]          hold_n  = 3'h7;
   logic                locked;
   logic [2:0]          src_n;
   tck_pkg::tck_cfg_t   cfg     = '0;
   tck_pkg::tck_rates_t rates;
   logic                h_n, v_n, a_n, vrst, ready;
   int                  mismatches = 0;
   int                  n_compared = 0;
   initial forever #20 clock_i = ~clock_i;
   tck_src_model #(.AUD_FS_HZ(AUD_FS)) SRC (.lock_req_i(lock_req),
      .hold_n_i(hold_n), .locked_o(locked), .rst_n_o(src_n),
      .host_khz_o(host_khz), .aud_hz_o(aud_hz));
   tck_plan #(.HOLD_CYCLES(HOLD)) DUT (.clock_i(clock_i), .ce_i(ce),
      .rst_i(rst_i), .cfg_i(cfg), .host_rst_n_i(src_n[2]),
      .vid_rst_n_i(src_n[1]), .aud_rst_n_i(src_n[0]),
      .clk_locked_i(locked), .rates_o(rates), .host_rst_n_o(h_n),
      .vid_rst_n_o(v_n), .aud_rst_n_o(a_n), .video_rst_o(vrst),
      .ready_o(ready));
   //------------------------------------------------------------------
   // helpers
   //------------------------------------------------------------------
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // edges until s reaches lvl; a hang counts as a mismatch
   task automatic edges_until(ref logic s, input logic lvl, output int n);
      n = 0;
      do
      begin
         @(posedge clock_i);
         #1;
         n++;
      end while (s !== lvl && n < 40);
      if (n >= 40)
      begin
         mismatches++;
         $display("unexpected at %0t: wait ran out", $time);
         summarize();
      end
   endtask
   function automatic tck_pkg::tck_rates_t exp_rates(tck_pkg::tck_cfg_t c);
      tck_pkg::tck_rates_t r;
      logic [31:0]         k;
      logic                hi;
      k  = c.rate_mbps * 32'h3E8;
      hi = c.rate_mbps > 16'hD48;
      r.cable_khz = hi ? k / `TCK_CABLE_DIV_HI : k / `TCK_CABLE_DIV_LO;
      r.data_khz  = hi ? r.cable_khz * `TCK_DATA_MUL_HI : r.cable_khz;
      r.link_khz  = r.data_khz / `TCK_LINK_DIV;
      case (c.bpc_sel)
         `TCK_BPC_8:  r.pixel_khz = r.data_khz;
         `TCK_BPC_10: r.pixel_khz = r.data_khz * 32'h4 / 32'h5;
         `TCK_BPC_12: r.pixel_khz = r.data_khz * 32'h2 / 32'h3;
         default:     r.pixel_khz = r.data_khz / 32'h2;
      endcase
      r.video_khz = c.quad_px ? r.pixel_khz / 32'h4 : r.pixel_khz / 32'h2;
      return r;
   endfunction
   //------------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------------
   task automatic t_rates();
      logic [15:0] tbl [4];
      tbl = '{16'hD20, 16'hD48, 16'hD49, 16'hD98};
      for (int i = 0; i < 4; i++)
         for (int b = 0; b < 8; b++)
         begin
            cfg = '{tbl[i], b[1:0], b[2], 1'b0};
            repeat (2) @(negedge clock_i);
            `CHK(rates, exp_rates(cfg))
         end
   endtask
   task automatic t_lock(input logic native);
      int n;
      cfg.native_sel = native;
      hold_n   = 3'h5;
      lock_req = 1'b1;
      edges_until(ready, 1'b1, n);
      `CHK(n, 3 + HOLD)
      `CHK({h_n, a_n}, 2'h3)
      `CHK(v_n, native)
      if (native)
         `CHK(vrst, 1'b0)
      @(negedge clock_i);
      hold_n = 3'h7;
      if (!native)
      begin
         edges_until(v_n, 1'b1, n);
         `CHK(n, 3)
      end
      @(negedge clock_i);
      lock_req = 1'b0;
      edges_until(h_n, 1'b0, n);
      `CHK(n, 3)
      @(negedge clock_i);
      `CHK({ready, a_n, v_n}, 3'h0)
      if (native)
         `CHK(vrst, 1'b1)
   endtask
   // freeze by clock enable, then a reset in mid-run
   task automatic t_freeze();
      tck_pkg::tck_rates_t held;
      int                  n;
      cfg      = '{16'hD98, 2'h1, 1'b1, 1'b1};
      lock_req = 1'b1;
      edges_until(ready, 1'b1, n);
      `CHK(n, 3 + HOLD)
      @(negedge clock_i);
      `CHK(rates, exp_rates(cfg))
      held     = rates;
      ce       = 1'b0;
      cfg      = '{16'hD20, 2'h0, 1'b0, 1'b0};
      lock_req = 1'b0;
      repeat (4) @(negedge clock_i);
      `CHK({rates, ready, h_n, vrst}, {held, 3'h6})
      ce       = 1'b1;
      lock_req = 1'b1;
      repeat (2) @(negedge clock_i);
      `CHK({rates, ready, vrst}, {exp_rates(cfg), 2'h3})
      rst_i = 1'b1;
      @(negedge clock_i);
      `CHK({rates, ready, h_n, vrst}, {161'h0, 2'h1})
      rst_i = 1'b0;
      edges_until(ready, 1'b1, n);
      `CHK(n, 3 + HOLD)
      @(negedge clock_i);
      lock_req = 1'b0;
   endtask
   //------------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------------
   initial
   begin
      repeat (6) @(negedge clock_i);
      `CHK({rates, ready, h_n, vrst}, {161'h0, 2'h1})
      `CHK(host_khz, `TCK_HOST_KHZ)
      `CHK(aud_hz >= AUD_FS * `TCK_AUD_RATIO, 1'b1)
      rst_i = 1'b0;
      t_rates();
      t_lock(1'b0);
      t_lock(1'b1);
      t_freeze();
      summarize();
   end
endmodule
